// file: design/asb_pkg.sv
// Package for the asynchronous SRAM host controller: pin bundles, commands, timing
`default_nettype none
package asb_pkg;
  localparam int unsigned CLK_PERIOD_NS = 4;
  localparam int unsigned ADDR_W = 18;
  localparam int unsigned DATA_W = 16;
  localparam int unsigned BYTE_W = 8;
  // Pin timing figures, ns, as printed for the 10 ns grade
  localparam int unsigned T_RC_NS = 10;
  localparam int unsigned T_AA_NS = 10;
  localparam int unsigned T_HZOE_NS = 5;
  localparam int unsigned T_PWE_NS = 7;
  localparam int unsigned T_SD_NS = 6;
  localparam int unsigned T_HZWE_NS = 5;
  localparam int unsigned T_CDR_NS = 0;
  // Least times round up, never below one cycle
  function automatic int unsigned cyc_up(input int unsigned ns);
    int unsigned c;
    c = (ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    return (c < 1) ? 1 : c;
  endfunction
  localparam int unsigned RD_CYC = cyc_up(T_AA_NS);
  localparam int unsigned WR_PULSE_CYC = cyc_up(T_PWE_NS);
  localparam int unsigned WR_SD_CYC = cyc_up(T_HZWE_NS + T_SD_NS);
  localparam int unsigned WR_CYC = (WR_PULSE_CYC > WR_SD_CYC) ? WR_PULSE_CYC : WR_SD_CYC;
  localparam int unsigned REC_CYC = cyc_up(T_RC_NS);
  localparam int unsigned CDR_CYC = cyc_up(T_CDR_NS);
  localparam int unsigned CNT_W = 4;
  // Byte select encodings, active low on the pins
  localparam logic [1:0] BE_NONE = 2'h3;

  // Pins that the controller drives
  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic chip_select_n;
    logic output_enable_n;
    logic write_enable_n;
    logic low_byte_enable_n;
    logic high_byte_enable_n;
  } asb_pins_t;

  // User request
  typedef struct packed {
    logic write;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic [1:0] byte_en;
  } asb_req_t;
endpackage
`default_nettype wire

// file: design/asb_sync.sv
// Two-flop synchroniser for the data lines read back from the memory
`default_nettype none
module asb_sync
  import asb_pkg::*;
#(
  parameter int unsigned WIDTH = DATA_W
)(
  input wire logic clock,
  input wire logic sys_rst,
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);
  logic [WIDTH-1:0] meta_q;
  // First stage is read only by the second
  always_ff @(posedge clock or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      meta_q <= '0;
      sync_out <= '0;
    end
    else
    begin
      meta_q <= async_in;
      sync_out <= meta_q;
    end
  end
endmodule
`default_nettype wire

// file: design/asb_host.sv
// Host controller that drives a 256K x 16 asynchronous SRAM through its pins
// Behaviour
// - Host holds data stable across the edge that ends the write.
// - Host never drives data lines while memory may be driving them.
// - Write cycle with output enable low lasts turn-off plus data set-up.
// - Host keeps write enable high throughout every read.
// - Address is valid no later than chip select falling for reads.
// - Chip select high before retention entry, no delay needed.
`default_nettype none
module asb_host
  import asb_pkg::*;
(
  input wire logic clock,
  input wire logic sys_rst,
  input wire logic req_valid,
  output logic req_ready,
  input wire asb_req_t req,
  output logic rsp_valid,
  output logic [DATA_W-1:0] rsp_rdata,
  input wire logic retention_req,
  output logic retention_ok,
  output asb_pins_t pins,
  output logic [DATA_W-1:0] data_lines_out,
  output logic [DATA_W-1:0] data_lines_oe_n,
  input wire logic [DATA_W-1:0] data_lines_in
);
  typedef enum logic [2:0] {ST_IDLE, ST_RD, ST_RD_CAP, ST_WR, ST_WR_END, ST_REC, ST_RET} asb_state_t;
  asb_state_t state_q;
  logic [CNT_W-1:0] cnt_q;
  logic [DATA_W-1:0] rd_sync;
  logic [1:0] be_q;
  logic wr_q;
  // Pin registers, one driver each, gathered into the pin bundle below
  logic [ADDR_W-1:0] addr_q;
  logic cs_n_q;
  logic oe_n_q;
  logic we_n_q;
  logic low_be_n_q;
  logic high_be_n_q;

  ////////////////////////////////////////////////////////////////
  // Pin read-back passes two flops before use
  asb_sync #(.WIDTH(DATA_W)) u_sync (
    .clock(clock),
    .sys_rst(sys_rst),
    .async_in(data_lines_in),
    .sync_out(rd_sync)
  );

  ////////////////////////////////////////////////////////////////
  // Sequencer; idle leaves chip deselected
  always_ff @(posedge clock or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      state_q <= ST_IDLE;
      cnt_q <= '0;
    end
    else
    begin
      case (state_q)
        ST_IDLE:
        begin
          cnt_q <= '0;
          if (retention_req)
            state_q <= ST_RET;
          else if (req_valid && req.byte_en != BE_NONE)
            state_q <= req.write ? ST_WR : ST_RD;
        end
        ST_RD:
        begin
          cnt_q <= cnt_q + 1'b1;
          // Extra cycles cover the two synchroniser stages
          if (cnt_q == CNT_W'(RD_CYC + 1))
            state_q <= ST_RD_CAP;
        end
        ST_RD_CAP:
        begin
          cnt_q <= '0;
          state_q <= ST_REC;
        end
        ST_WR:
        begin
          cnt_q <= cnt_q + 1'b1;
          if (cnt_q == CNT_W'(WR_CYC - 1))
            state_q <= ST_WR_END;
        end
        ST_WR_END:
        begin
          cnt_q <= '0;
          state_q <= ST_REC;
        end
        ST_REC:
        begin
          cnt_q <= cnt_q + 1'b1;
          if (cnt_q == CNT_W'(REC_CYC - 1))
            state_q <= ST_IDLE;
        end
        ST_RET:
        begin
          cnt_q <= '0;
          if (!retention_req)
            state_q <= ST_REC;
        end
        default:
          state_q <= ST_IDLE;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////
  // Latch request fields at acceptance; address set on the same edge that select falls
  always_ff @(posedge clock or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      addr_q <= '0;
      data_lines_out <= '0;
      be_q <= BE_NONE;
      wr_q <= 1'b0;
    end
    else if (state_q == ST_IDLE && !retention_req && req_valid && req.byte_en != BE_NONE)
    begin
      addr_q <= req.addr;
      data_lines_out <= req.wdata;
      be_q <= req.byte_en;
      wr_q <= req.write;
    end
  end

  ////////////////////////////////////////////////////////////////
  // Control pins, registered so no glitch reaches the memory
  always_ff @(posedge clock or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      cs_n_q <= 1'b1;
      oe_n_q <= 1'b1;
      we_n_q <= 1'b1;
      low_be_n_q <= 1'b1;
      high_be_n_q <= 1'b1;
    end
    else
    begin
      // Select only in active access states; standby otherwise
      cs_n_q <= !(state_q == ST_IDLE && !retention_req && req_valid && req.byte_en != BE_NONE
                  || state_q == ST_RD || state_q == ST_WR && cnt_q != CNT_W'(WR_CYC - 1));
      // Output enable only for reads; held high across writes
      oe_n_q <= !(state_q == ST_IDLE && !retention_req && req_valid && !req.write
                  && req.byte_en != BE_NONE || state_q == ST_RD);
      // Write enable falls with select and both rise on the same edge
      we_n_q <= !(state_q == ST_IDLE && !retention_req && req_valid && req.write
                  && req.byte_en != BE_NONE || state_q == ST_WR && cnt_q != CNT_W'(WR_CYC - 1));
      // Byte enables follow the request; released with select after reads, one cycle after select after writes (low in first standby cycle)
      if (state_q == ST_IDLE && !retention_req && req_valid && req.byte_en != BE_NONE)
      begin
        low_be_n_q <= req.byte_en[0];
        high_be_n_q <= req.byte_en[1];
      end
      else if (!(state_q == ST_RD || state_q == ST_WR))
      begin
        low_be_n_q <= 1'b1;
        high_be_n_q <= 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////
  // Data drive: only during write and its hold cycle, OE already high
  always_ff @(posedge clock or posedge sys_rst)
  begin
    if (sys_rst)
      data_lines_oe_n <= '1;
    else if (state_q == ST_IDLE && !retention_req && req_valid && req.write && req.byte_en != BE_NONE)
      data_lines_oe_n <= '0;
    else if (state_q == ST_WR_END)
      data_lines_oe_n <= '1;
  end

  ////////////////////////////////////////////////////////////////
  // Read data capture; unselected byte lanes return zero
  always_ff @(posedge clock or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      rsp_valid <= 1'b0;
      rsp_rdata <= '0;
    end
    else
    begin
      rsp_valid <= (state_q == ST_RD_CAP) || (state_q == ST_WR_END);
      if (state_q == ST_RD_CAP)
      begin
        rsp_rdata[BYTE_W-1:0] <= be_q[0] ? '0 : rd_sync[BYTE_W-1:0];
        rsp_rdata[DATA_W-1:BYTE_W] <= be_q[1] ? '0 : rd_sync[DATA_W-1:BYTE_W];
      end
    end
  end

  // Pin bundle straight from the pin registers
  assign pins = '{addr: addr_q, chip_select_n: cs_n_q, output_enable_n: oe_n_q, write_enable_n: we_n_q,
                  low_byte_enable_n: low_be_n_q, high_byte_enable_n: high_be_n_q};
  assign req_ready = (state_q == ST_IDLE) && !retention_req;
  assign retention_ok = (state_q == ST_RET) && pins.chip_select_n;

  ////////////////////////////////////////////////////////////////
  // Checks
  sequence wr_start_s;
    !pins.write_enable_n && $fell(pins.write_enable_n);
  endsequence
  property wr_oe_high_p;
    @(posedge clock) disable iff (sys_rst) !pins.write_enable_n |-> pins.output_enable_n;
  endproperty
  read_we_high_a: assert property (@(posedge clock) disable iff (sys_rst)
    !pins.output_enable_n |-> pins.write_enable_n) else $error("write enable low in read");
  write_no_oe_a: assert property (wr_oe_high_p) else $error("output enable low in write");
  drive_no_oe_a: assert property (@(posedge clock) disable iff (sys_rst)
    (data_lines_oe_n != '1) |-> pins.output_enable_n) else $error("bus fight");
  write_pulse_len_a: assert property (@(posedge clock) disable iff (sys_rst)
    wr_start_s |-> !pins.write_enable_n [*3]) else $error("write pulse short");
  joint_rise_a: assert property (@(posedge clock) disable iff (sys_rst)
    $rose(pins.write_enable_n) |-> $rose(pins.chip_select_n)) else $error("edges split");
  data_hold_a: assert property (@(posedge clock) disable iff (sys_rst)
    $rose(pins.write_enable_n) |-> (data_lines_oe_n == '0) && $stable(data_lines_out))
    else $error("data not held");
  addr_stable_a: assert property (@(posedge clock) disable iff (sys_rst)
    !pins.chip_select_n && !$rose(pins.chip_select_n) && !$fell(pins.chip_select_n) |-> $stable(pins.addr))
    else $error("address moved");
  ret_deselect_a: assert property (@(posedge clock) disable iff (sys_rst)
    retention_ok |=> pins.chip_select_n) else $error("selected in retention");
  be_idle_a: assert property (@(posedge clock) disable iff (sys_rst)
    pins.chip_select_n && $past(pins.chip_select_n) |-> pins.low_byte_enable_n && pins.high_byte_enable_n)
    else $error("byte enable in standby");
endmodule
`default_nettype wire

// file: testbench/asb_sram_model.sv
// Behavioural model of the 256K x 16 asynchronous static RAM behind the controller
`default_nettype none
module asb_sram_model
  import asb_pkg::*;
#(
  parameter logic [DATA_W-1:0] BLANK = 16'h3C96
)(
  input wire asb_pins_t pins,
  input wire logic [DATA_W-1:0] host_out,
  input wire logic [DATA_W-1:0] host_oe_n,
  output logic [DATA_W-1:0] data_lines,
  output logic clash
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [DATA_W-1:0] mem [logic [ADDR_W-1:0]];
  logic [DATA_W-1:0] noise = 16'h5A5A;
  logic [DATA_W-1:0] dev_q;
  logic [DATA_W-1:0] dev_en;
  logic [DATA_W-1:0] word;
  logic writing;
  ////////////////////////////////////////////////////////////////////////////////
  // Undriven lines wander, so a stale value is never mistaken for data
  always #2 noise = ~noise;
  // Write window is the overlap of select and write enable
  assign writing = !pins.chip_select_n && !pins.write_enable_n;
  // Read drive per lane; floats when deselected, writing or disabled
  always @*
  begin
    dev_en = '0;
    if (!pins.chip_select_n && pins.write_enable_n && !pins.output_enable_n)
    begin
      dev_en[7:0] = {8{!pins.low_byte_enable_n}};
      dev_en[15:8] = {8{!pins.high_byte_enable_n}};
    end
    dev_q = mem.exists(pins.addr) ? mem[pins.addr] : BLANK;
  end
  // Resolved wire level per line
  always @*
  begin
    for (int i = 0; i < DATA_W; i++)
      data_lines[i] = !host_oe_n[i] ? host_out[i] : dev_en[i] ? dev_q[i] : noise[i];
  end
  assign clash = |(dev_en & ~host_oe_n);
  ////////////////////////////////////////////////////////////////////////////////
  // Store at the edge ending the write, from the lines as they stand then
  always @(negedge writing)
  begin
    if ($time > 0)
    begin
      word = mem.exists(pins.addr) ? mem[pins.addr] : BLANK;
      if (!pins.low_byte_enable_n)
        word[7:0] = data_lines[7:0];
      if (!pins.high_byte_enable_n)
        word[15:8] = data_lines[15:8];
      mem[pins.addr] = word;
    end
  end
endmodule
`default_nettype wire

// file: testbench/tb_top.sv
// Self-checking bench for the asynchronous SRAM host controller
`default_nettype none
module tb_top
  import asb_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  localparam int WR_LAT = 4;
  localparam int RD_LAT = 6;
  localparam logic [ADDR_W-1:0] A1 = 18'h00001;
  logic clock = 1'b0;
  logic sys_rst = 1'b1;
  logic req_valid = 1'b0;
  logic retention_req = 1'b0;
  asb_req_t req = '0;
  logic req_ready, rsp_valid, retention_ok, clash;
  logic [DATA_W-1:0] rsp_rdata, data_lines_out, data_lines_oe_n, data_lines, got;
  asb_pins_t pins;
  int mismatches = 0;
  int samples_checked = 0;
  ////////////////////////////////////////////////////////////////////////////////
  always #2 clock = ~clock;
  asb_host dut (.clock(clock), .sys_rst(sys_rst), .req_valid(req_valid), .req_ready(req_ready), .req(req),
    .rsp_valid(rsp_valid), .rsp_rdata(rsp_rdata), .retention_req(retention_req), .retention_ok(retention_ok),
    .pins(pins), .data_lines_out(data_lines_out), .data_lines_oe_n(data_lines_oe_n), .data_lines_in(data_lines));
  asb_sram_model mem_model (.pins(pins), .host_out(data_lines_out), .host_oe_n(data_lines_oe_n),
    .data_lines(data_lines), .clash(clash));
  ////////////////////////////////////////////////////////////////////////////////
  task automatic final_report();
    $display("compares %0d mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] seen);
    samples_checked++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // A bound that runs out ends the run at once
  task automatic bound(input string what, input int n, input int lim);
    if (n >= lim)
    begin
      chk(what, 1, 0);
      final_report();
    end
  endtask
  // One request, held until taken; latency counted from the take edge
  task automatic access(input logic wr, input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d,
                        input logic [1:0] be, output logic [DATA_W-1:0] rd);
    int n;
    n = 0;
    @(negedge clock);
    req = '{write: wr, addr: a, wdata: d, byte_en: be};
    req_valid = 1'b1;
    while (req_ready !== 1'b1 && n < 50)
    begin
      @(negedge clock);
      n++;
    end
    bound("ready wait", n, 50);
    @(negedge clock);
    req_valid = 1'b0;
    chk("address at select", a, pins.addr);
    chk("select low", 0, pins.chip_select_n);
    n = 0;
    while (rsp_valid !== 1'b1 && n < 50)
    begin
      @(negedge clock);
      n++;
    end
    bound("response wait", n, 50);
    chk("latency", wr ? WR_LAT : RD_LAT, n);
    rd = rsp_rdata;
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  // Every cycle: no contention, write enable high in reads, no read drive in writes
  always @(negedge clock)
  begin
    if (!sys_rst)
    begin
      chk("contention", 0, clash);
      chk("we_n in read", 1, pins.output_enable_n | pins.chip_select_n | pins.write_enable_n);
      chk("oe_n in write", 1, pins.write_enable_n | pins.output_enable_n);
      chk("cs_n parked", 1, !retention_ok | pins.chip_select_n);
    end
  end
  ////////////////////////////////////////////////////////////////////////////////
  task automatic sc_full();
    access(1'b1, 18'h3FFFF, 16'hBEEF, 2'h0, got);
    access(1'b0, 18'h3FFFF, 16'h0000, 2'h0, got);
    chk("full read", 16'hBEEF, got);
  endtask
  // Byte lanes written and read back to back at one word
  task automatic sc_bytes();
    access(1'b1, A1, 16'h1234, 2'h0, got);
    access(1'b1, A1, 16'hAAC5, 2'h2, got);
    access(1'b0, A1, 16'h0000, 2'h0, got);
    chk("low byte write", 16'h12C5, got);
    access(1'b1, A1, 16'h7E99, 2'h1, got);
    access(1'b0, A1, 16'h0000, 2'h0, got);
    chk("high byte write", 16'h7EC5, got);
    access(1'b0, A1, 16'h0000, 2'h2, got);
    chk("low byte read", 16'h00C5, got);
    access(1'b0, A1, 16'h0000, 2'h1, got);
    chk("high byte read", 16'h7E00, got);
  endtask
  // No lanes enabled: never taken, memory never selected
  task automatic sc_refuse();
    int n;
    n = 0;
    @(negedge clock);
    req = '{write: 1'b1, addr: A1, wdata: 16'h0000, byte_en: BE_NONE};
    req_valid = 1'b1;
    // Let the recovery of the last access run out first
    while (req_ready !== 1'b1 && n < 20)
    begin
      @(negedge clock);
      n++;
    end
    bound("idle wait", n, 20);
    repeat (12)
    begin
      @(negedge clock);
      chk("idle select", 1, pins.chip_select_n);
      chk("no response", 0, rsp_valid);
      chk("ready held", 1, req_ready);
    end
    req_valid = 1'b0;
    access(1'b0, A1, 16'h0000, 2'h0, got);
    chk("word untouched", 16'h7EC5, got);
  endtask
  // Park for retention, then resume with data intact
  task automatic sc_retain();
    int n;
    n = 0;
    @(negedge clock);
    retention_req = 1'b1;
    while (retention_ok !== 1'b1 && n < 20)
    begin
      @(negedge clock);
      n++;
    end
    bound("retention wait", n, 20);
    chk("ready parked", 0, req_ready);
    chk("select parked", 1, pins.chip_select_n);
    repeat (3)
    begin
      @(negedge clock);
      chk("select held parked", 1, pins.chip_select_n);
      chk("park held", 1, retention_ok);
    end
    retention_req = 1'b0;
    access(1'b0, 18'h3FFFF, 16'h0000, 2'h0, got);
    chk("data kept", 16'hBEEF, got);
  endtask
  // Reset in the middle of a write parks every pin; later accesses run normally
  task automatic sc_reset();
    int n;
    n = 0;
    @(negedge clock);
    req = '{write: 1'b1, addr: 18'h00002, wdata: 16'hC3A5, byte_en: 2'h0};
    req_valid = 1'b1;
    while (req_ready !== 1'b1 && n < 20)
    begin
      @(negedge clock);
      n++;
    end
    bound("reset take wait", n, 20);
    @(negedge clock);
    req_valid = 1'b0;
    chk("select before reset", 0, pins.chip_select_n);
    sys_rst = 1'b1;
    @(negedge clock);
    chk("select in reset", 1, pins.chip_select_n);
    chk("write enable in reset", 1, pins.write_enable_n);
    chk("drive in reset", 16'hFFFF, data_lines_oe_n);
    chk("response in reset", 0, rsp_valid);
    sys_rst = 1'b0;
    access(1'b1, 18'h00002, 16'hC3A5, 2'h0, got);
    access(1'b0, 18'h00002, 16'h0000, 2'h0, got);
    chk("word after reset", 16'hC3A5, got);
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial
  begin
    repeat (8) @(posedge clock);
    @(negedge clock);
    sys_rst = 1'b0;
    sc_full();
    sc_bytes();
    sc_refuse();
    sc_retain();
    sc_reset();
    final_report();
  end
endmodule
`default_nettype wire
